// >>> verilog/lpo_defs.vh
`ifndef LPO_DEFS_VH
`define LPO_DEFS_VH
`define LPO_ADDR_BASE 7'h58
`define LPO_REG_POWER 8'h01
`define LPO_REG_OVERRIDE 8'h02
`define LPO_REG_SPARE3 8'h03
`define LPO_REG_SPARE4 8'h04
`define LPO_REG_SPARE5 8'h05
`define LPO_REG_SLAVE 8'h06
`define LPO_RST_POWER 8'h00
`define LPO_RST_OVERRIDE 8'h00
`define LPO_RST_SPARE 8'h00
`define LPO_RST_SLAVE 8'h10
`define LPO_BIT_OVERRIDE 0
`define LPO_BIT_REG_EN 3
`define LPO_READ_FILL 8'h00
`endif

// >>> verilog/lpo_sync.v
`default_nettype none
module lpo_sync
  (
  input wire clock,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_in,
  output reg scl_rise,
  output reg scl_fall,
  output reg start_seen,
  output reg stop_seen,
  output reg sda_now
  );
  reg scl_q;
  reg sda_q;
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_rise <= 1'b0;
      scl_fall <= 1'b0;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
      sda_now <= 1'b1;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      sda_now <= sda_in;
      scl_rise <= scl_in & ~scl_q;
      scl_fall <= ~scl_in & scl_q;
      // SDA edge while SCL high frames a message
      start_seen <= scl_in & scl_q & sda_q & ~sda_in;
      stop_seen <= scl_in & scl_q & ~sda_q & sda_in;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/lpo_shift.v
`default_nettype none
module lpo_shift
  #(
  parameter WIDTH = 8
  )
  (
  input wire clock,
  input wire sys_rst,
  input wire clear,
  input wire shift_en,
  input wire bit_in,
  output reg [WIDTH-1:0] value,
  output reg [3:0] count
  );
  always @(posedge clock)
  begin
    if (sys_rst || clear)
    begin
      value <= {WIDTH{1'b0}};
      count <= 4'h0;
    end
    else if (shift_en)
    begin
      value <= {value[WIDTH-2:0], bit_in};
      count <= count + 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/lpo_regs.v
`default_nettype none
`include "lpo_defs.vh"
// Contract
// - One power-down bit per lane, eight lanes
// - Lane power resets zero; ones disable all
// - Lane bits govern only under override
// - Override set ignores pin, else pin
// - Bit three enables slave register control
// - Conditioning changes accepted only when enabled
// - Slave control register resets to 0x10
// - Write: address, register, data, each acknowledged
// - Straps select slave address, default B0
module lpo_regs
  (
  input wire clock,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire [3:0] addr_strap,
  input wire power_down_pin,
  input wire [7:0] pin_lane_power,
  input wire cond_write,
  input wire [7:0] cond_data,
  output reg [7:0] lane_power,
  output reg override_active,
  output reg reg_enable,
  output reg cond_load,
  output reg [7:0] cond_value,
  output reg [7:0] lane_power_down,
  output reg [7:0] pin_override_control,
  output reg [7:0] slave_register_enable
  );
  localparam ST_IDLE = 7'h01;
  localparam ST_ADDR = 7'h02;
  localparam ST_AACK = 7'h04;
  localparam ST_RADR = 7'h08;
  localparam ST_DATA = 7'h10;
  localparam ST_DACK = 7'h20;
  localparam ST_SEND = 7'h40;
  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;
  wire sda_now;
  wire [7:0] shift_value;
  wire [3:0] shift_count;
  reg [6:0] state;
  reg [6:0] next_state;
  reg [7:0] reg_ptr;
  reg [7:0] spare_three;
  reg [7:0] spare_four;
  reg [7:0] spare_five;
  reg [7:0] tx_byte;
  reg [3:0] tx_count;
  reg ptr_loaded;
  reg reading;
  reg [3:0] strap_q;
  reg [7:0] read_data;
  wire shift_clear;
  wire shift_en;
  wire [6:0] my_addr;
  wire byte_done;
  lpo_sync u_sync
    (
    .clock(clock),
    .sys_rst(sys_rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen),
    .sda_now(sda_now)
    );
  assign shift_clear = start_seen | (scl_fall & (state == ST_AACK || state == ST_DACK));
  assign shift_en = scl_rise & (state == ST_ADDR || state == ST_RADR || state == ST_DATA);
  lpo_shift #(.WIDTH(8)) u_shift
    (
    .clock(clock),
    .sys_rst(sys_rst),
    .clear(shift_clear),
    .shift_en(shift_en),
    .bit_in(sda_now),
    .value(shift_value),
    .count(shift_count)
    );
  // strap address decode
  // Straps add to the base; an OR would alias strap codes onto base bits
  assign my_addr = `LPO_ADDR_BASE + {3'b000, strap_q};
  assign byte_done = (shift_count == 4'h8);
  // Straps sampled each cycle; caught after reset release
  always @(posedge clock)
  begin
    if (sys_rst)
      strap_q <= 4'h0;
    else
      strap_q <= addr_strap;
  end
  always @*
  begin
    case (reg_ptr)
      `LPO_REG_POWER: read_data = lane_power_down;
      `LPO_REG_OVERRIDE: read_data = pin_override_control;
      `LPO_REG_SPARE3: read_data = spare_three;
      `LPO_REG_SPARE4: read_data = spare_four;
      `LPO_REG_SPARE5: read_data = spare_five;
      `LPO_REG_SLAVE: read_data = slave_register_enable;
      default: read_data = `LPO_READ_FILL;
    endcase
  end
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = ST_IDLE;
      ST_ADDR:
        if (byte_done && scl_fall)
          next_state = (shift_value[7:1] == my_addr) ? ST_AACK : ST_IDLE;
      ST_AACK:
        if (scl_fall)
          next_state = reading ? ST_SEND : (ptr_loaded ? ST_DATA : ST_RADR);
      ST_RADR:
        if (byte_done && scl_fall)
          next_state = ST_DACK;
      ST_DATA:
        if (byte_done && scl_fall)
          next_state = ST_DACK;
      ST_DACK:
        if (scl_fall)
          next_state = ST_DATA;
      ST_SEND:
        if (scl_rise && tx_count == 4'h8)
          next_state = sda_now ? ST_IDLE : ST_SEND;
      default: next_state = ST_IDLE;
    endcase
    if (stop_seen)
      next_state = ST_IDLE;
    if (start_seen)
      next_state = ST_ADDR;
  end
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      state <= ST_IDLE;
      reg_ptr <= 8'h00;
      ptr_loaded <= 1'b0;
      reading <= 1'b0;
      tx_byte <= 8'h00;
      tx_count <= 4'h0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      lane_power_down <= `LPO_RST_POWER;
      pin_override_control <= `LPO_RST_OVERRIDE;
      spare_three <= `LPO_RST_SPARE;
      spare_four <= `LPO_RST_SPARE;
      spare_five <= `LPO_RST_SPARE;
      slave_register_enable <= `LPO_RST_SLAVE;
    end
    else
    begin
      state <= next_state;
      if (start_seen)
      begin
        ptr_loaded <= ptr_loaded & ~reading;
        sda_oe <= 1'b0;
      end
      if (stop_seen)
      begin
        ptr_loaded <= 1'b0;
        sda_oe <= 1'b0;
      end
      if (state == ST_ADDR && byte_done && scl_fall)
      begin
        reading <= shift_value[0];
        sda_oe <= (shift_value[7:1] == my_addr);
        if (!shift_value[0])
          ptr_loaded <= 1'b0;
      end
      if ((state == ST_RADR || state == ST_DATA) && byte_done && scl_fall)
      begin
        sda_oe <= 1'b1;
        if (state == ST_RADR)
        begin
          reg_ptr <= shift_value;
          ptr_loaded <= 1'b1;
        end
        else
        begin
          case (reg_ptr)
            `LPO_REG_POWER: lane_power_down <= shift_value;
            `LPO_REG_OVERRIDE: pin_override_control <= shift_value;
            `LPO_REG_SPARE3: spare_three <= shift_value;
            `LPO_REG_SPARE4: spare_four <= shift_value;
            `LPO_REG_SPARE5: spare_five <= shift_value;
            `LPO_REG_SLAVE: slave_register_enable <= shift_value;
            default: reg_ptr <= reg_ptr;
          endcase
          reg_ptr <= reg_ptr + 8'h01;
        end
      end
      if ((state == ST_AACK || state == ST_DACK) && scl_fall)
      begin
        sda_oe <= 1'b0;
        if (state == ST_AACK && reading)
        begin
          tx_byte <= read_data;
          tx_count <= 4'h0;
          sda_oe <= ~read_data[7];
        end
      end
      if (state == ST_SEND && scl_fall)
      begin
        if (tx_count == 4'h8)
        begin
          tx_byte <= read_data;
          tx_count <= 4'h0;
          sda_oe <= ~read_data[7];
        end
        else if (tx_count == 4'h7)
        begin
          // Release for the master's acknowledge bit
          tx_count <= 4'h8;
          sda_oe <= 1'b0;
          reg_ptr <= reg_ptr + 8'h01;
        end
        else
        begin
          tx_count <= tx_count + 4'h1;
          tx_byte <= {tx_byte[6:0], 1'b0};
          sda_oe <= ~tx_byte[6];
        end
      end
    end
  end
  // Outputs registered; pin-driven power follows the pin
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      lane_power <= 8'h00;
      override_active <= 1'b0;
      reg_enable <= 1'b0;
      cond_load <= 1'b0;
      cond_value <= 8'h00;
    end
    else
    begin
      override_active <= pin_override_control[`LPO_BIT_OVERRIDE];
      reg_enable <= slave_register_enable[`LPO_BIT_REG_EN];
      if (pin_override_control[`LPO_BIT_OVERRIDE])
        lane_power <= lane_power_down;
      else
        lane_power <= power_down_pin ? 8'hff : pin_lane_power;
      cond_load <= cond_write & slave_register_enable[`LPO_BIT_REG_EN];
      if (cond_write && slave_register_enable[`LPO_BIT_REG_EN])
        cond_value <= cond_data;
    end
  end
endmodule
`default_nettype wire

// >>> verification/lpo_regs_asserts.sv
`default_nettype none
module lpo_regs_asserts (
  input wire logic clock, sys_rst, scl_in, sda_in, sda_out, sda_oe,
  input wire logic [3:0] addr_strap,
  input wire logic power_down_pin,
  input wire logic [7:0] pin_lane_power,
  input wire logic cond_write,
  input wire logic [7:0] cond_data, lane_power,
  input wire logic override_active, reg_enable, cond_load,
  input wire logic [7:0] cond_value, lane_power_down, pin_override_control,
  input wire logic [7:0] slave_register_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pin_src;
  assign pin_src = pin_lane_power | {8{power_down_pin}};
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  sequence s_ovr_steady;
    $stable(pin_override_control) [*2];
  endsequence
  sequence s_en_steady;
    $stable(slave_register_enable) [*2];
  endsequence
  a_reset_values: assert property (
    $fell(sys_rst) |-> !lane_power_down && !pin_override_control
      && slave_register_enable == 8'h10) else $error("reset value wrong");
  a_override_bit: assert property (
    s_ovr_steady |-> override_active == pin_override_control[0])
    else $error("override flag wrong");
  a_enable_bit: assert property (
    s_en_steady |-> reg_enable == slave_register_enable[3]) else $error("enable flag wrong");
  a_lane_reg: assert property (
    pin_override_control[0] && override_active |=> lane_power == $past(lane_power_down))
    else $error("lane power not from register");
  a_lane_pin: assert property (
    !pin_override_control[0] && !override_active |=> lane_power == $past(pin_src))
    else $error("lane power not from pin");
  a_cond_take: assert property (
    cond_write && reg_enable && slave_register_enable[3] |=>
      cond_load && cond_value == $past(cond_data)) else $error("setting not taken");
  a_cond_refuse: assert property (
    cond_load |-> $past(cond_write) && $past(slave_register_enable[3]))
    else $error("setting taken while disabled");
  a_ack_low: assert property (
    $rose(sda_oe) |-> !scl_in && !sda_out) else $error("data line driven wrongly");
endmodule
`default_nettype wire

// >>> verification/lpo_host.sv
`default_nettype none
module lpo_host (
  input wire logic clock,
  input wire logic sda_line,
  output var logic scl,
  output var logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx;
  logic [7:0] data;
  int nacks;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
    nacks = 0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic bit_io(input logic b);
    sda_low = !b;
    tick(6);
    scl = 1'b1;
    tick(3);
    rx = {rx[6:0], sda_line};
    tick(3);
    scl = 1'b0;
    tick(2);
  endtask
  // start when stop is 0, else stop; clock idles high
  task automatic frame(input logic stop);
    sda_low = stop;
    tick(3);
    scl = 1'b1;
    tick(3);
    sda_low = !stop;
    tick(3);
    scl = stop;
    tick(2);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i]);
    data = rx;
    bit_io(1'b1);
    if (!last && rx[0])
      nacks++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] r, input logic [7:0] d);
    frame(1'b0);
    byte_io(a, 1'b0);
    byte_io(r, 1'b0);
    byte_io(d, 1'b0);
    frame(1'b1);
  endtask
  // read ends with a refused byte
  task automatic rd(input logic [7:0] a, input logic [7:0] r);
    frame(1'b0);
    byte_io(a, 1'b0);
    byte_io(r, 1'b0);
    frame(1'b0);
    byte_io(a | 8'h01, 1'b0);
    byte_io(8'hff, 1'b1);
    frame(1'b1);
  endtask
endmodule
`default_nettype wire

// >>> verification/tb_lpo_regs.sv
`default_nettype none
module tb_lpo_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, sys_rst, scl, sda_low, sda_out, sda_oe, power_down_pin, cond_write;
  logic override_active, reg_enable, cond_load;
  logic [3:0] addr_strap;
  logic [7:0] pin_lane_power, cond_data, lane_power, cond_value, a, d;
  logic [7:0] lane_power_down, pin_override_control, slave_register_enable;
  int fails, check_count, seed;
  wire sda_line = !sda_low && !(sda_oe && !sda_out);
  lpo_host host (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  lpo_regs dut (.clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(addr_strap),
    .power_down_pin(power_down_pin), .pin_lane_power(pin_lane_power),
    .cond_write(cond_write), .cond_data(cond_data), .lane_power(lane_power),
    .override_active(override_active), .reg_enable(reg_enable), .cond_load(cond_load),
    .cond_value(cond_value), .lane_power_down(lane_power_down),
    .pin_override_control(pin_override_control),
    .slave_register_enable(slave_register_enable));
  function automatic logic [7:0] pin_exp();
    return pin_lane_power | {8{power_down_pin}};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cond_try(input logic en);
    cond_data = $random(seed);
    cond_write = 1'b1;
    @(negedge clock);
    cond_write = 1'b0;
    chk("cond_load", {7'h0, en}, {7'h0, cond_load});
    if (en)
      chk("cond_value", cond_data, cond_value);
  endtask
  task automatic summarize();
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial
  begin
    #200000;
    fails++;
    summarize();
  end
  initial
  begin
    seed = 32'hd4b57168;
    sys_rst = 1'b1;
    addr_strap = $random(seed);
    power_down_pin = 1'b0;
    pin_lane_power = $random(seed);
    cond_write = 1'b0;
    cond_data = 8'h00;
    repeat (6) @(negedge clock);
    sys_rst = 1'b0;
    a = 8'hb0 + {3'h0, addr_strap, 1'b0};
    cond_try(1'b0);
    for (int r = 0; r < 7; r++)
    begin
      host.rd(a, r[7:0]);
      chk("reset", r == 6 ? 8'h10 : 8'h00, host.data);
    end
    for (int i = 0; i < 4; i++)
    begin
      d = (i == 0) ? 8'hff : $random(seed);
      pin_lane_power = $random(seed);
      power_down_pin = i[0];
      host.wr(a, 8'h01, d);
      chk("pin lanes", pin_exp(), lane_power);
      host.wr(a, 8'h02, 8'h01);
      chk("reg lanes", d, lane_power);
      host.wr(a, 8'h02, 8'h00);
    end
    host.rd(a, 8'h01);
    chk("readback", d, host.data);
    chk("acks", 8'h00, 8'(host.nacks));
    host.wr(a ^ 8'h02, 8'h02, 8'h01);
    chk("nack", 8'h01, {7'h0, host.nacks != 0});
    chk("no write", 8'h00, pin_override_control);
    host.wr(a, 8'h06, 8'h18);
    chk("enable", 8'h01, {7'h0, reg_enable});
    cond_try(1'b1);
    host.wr(a, 8'h06, 8'h10);
    cond_try(1'b0);
    summarize();
  end
endmodule
bind lpo_regs lpo_regs_asserts chk_i (.clock(clock), .sys_rst(sys_rst), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(addr_strap),
  .power_down_pin(power_down_pin), .pin_lane_power(pin_lane_power),
  .cond_write(cond_write), .cond_data(cond_data), .lane_power(lane_power),
  .override_active(override_active), .reg_enable(reg_enable), .cond_load(cond_load),
  .cond_value(cond_value), .lane_power_down(lane_power_down),
  .pin_override_control(pin_override_control),
  .slave_register_enable(slave_register_enable));
`default_nettype wire
